// >>> rtl/fault_pkg.sv
// Constants and types shared by the fault-flag and boost protection logic
package fault_pkg;

  // Register offsets on the register port
  localparam logic [7:0] OPEN_FLAGS_ADDR   = 8'hB0;  // Open fault flags
  localparam logic [7:0] SHORT_FLAGS_ADDR  = 8'hB1;  // Short fault flags
  localparam logic [7:0] FAULT_EN_ADDR     = 8'hB2;  // Fault detect enables
  localparam logic [7:0] BOOST_STATUS_ADDR = 8'hB3;  // Boost protection status
  localparam logic [7:0] OVP_SEL_ADDR      = 8'h2C;  // Over-voltage level select

  // Fault enable register fields
  localparam int OPEN_EN_BIT  = 0;                   // Open detection enable
  localparam int SHORT_EN_BIT = 1;                   // Short detection enable
  localparam logic [1:0] FAULT_EN_RESET = 2'h0;      // Both detections off

  // Flag register layout
  localparam int HV_COUNT     = 2;                   // High-voltage sinks
  localparam int LV_COUNT     = 5;                   // Low-voltage sinks
  localparam int HV_FIELD_LSB = 0;                   // High-voltage bits start
  localparam int LV_FIELD_LSB = 2;                   // Low-voltage bits start
  localparam int FLAG_WIDTH   = 7;                   // Used flag bits

  // Boost status register fields
  localparam int STATUS_OVP_BIT = 0;                 // Switching halted by OVER_VOLTAGE_LIMIT
  localparam int STATUS_OCP_BIT = 1;                 // Cycle ended by current limit

  // Over-voltage level select field
  localparam int OVP_SEL_LSB = 0;                    // Field position
  typedef enum logic [1:0] {
    OVP_16V = 2'b00,
    OVP_24V = 2'b01,
    OVP_32V = 2'b10,
    OVP_40V = 2'b11
  } ovp_level_t;
  localparam ovp_level_t OVP_SEL_RESET = OVP_16V;    // Power-up level

  // Comparator trip points served by the analog front end
  localparam int HV_OPEN_TRIP_MV    = 200;           // High-voltage sink floor
  localparam int LV_OPEN_TRIP_MV    = 110;           // Low-voltage sink floor
  localparam int SHORT_TRIP_MV      = 1000;          // Short detect margin
  localparam int OVP_HYSTERESIS_MV  = 1000;          // Restart margin
  localparam int SWITCH_LIMIT_MA    = 1000;          // Switch current limit

  // Boost protection state
  typedef enum logic {
    BOOST_RUN  = 1'b0,
    BOOST_HOLD = 1'b1
  } boost_state_t;

endpackage

// >>> rtl/flag_qualifier.sv
// Enable-gated fault flag bank: one registered flag per condition bit
`timescale 1ns/1ns
`default_nettype none

module flag_qualifier #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] condition,
  output logic      [WIDTH-1:0] flags_reg
);

  // Flags follow the qualified comparators, zero while disabled
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_reg <= '0;
    end
    else if (enable)
    begin
      flags_reg <= condition;
    end
    else
    begin
      flags_reg <= '0;
    end
  end

endmodule // flag_qualifier

`default_nettype wire

// >>> rtl/led_fault_flag_protection.sv
// LED open/short fault flags and boost over-voltage / current-limit control
`timescale 1ns/1ns
`default_nettype none

module led_fault_flag_protection (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // Register port
  input  wire logic [7:0]                     reg_addr,
  input  wire logic                           reg_wr,
  input  wire logic [7:0]                     reg_wdata,
  input  wire logic                           reg_rd,
  output logic      [7:0]                     reg_rdata,
  // High-voltage sink comparators
  input  wire logic [fault_pkg::HV_COUNT-1:0] hv_sink_active,
  input  wire logic [fault_pkg::HV_COUNT-1:0] hv_sink_low,
  input  wire logic [fault_pkg::HV_COUNT-1:0] hv_anode_on_boost,
  input  wire logic [fault_pkg::HV_COUNT-1:0] hv_string_short,
  // Low-voltage sink comparators
  input  wire logic [fault_pkg::LV_COUNT-1:0] lv_sink_active,
  input  wire logic [fault_pkg::LV_COUNT-1:0] lv_sink_low,
  input  wire logic [fault_pkg::LV_COUNT-1:0] lv_led_short,
  // Boost converter sensing
  input  wire logic                           boost_at_ovp,
  input  wire logic                           boost_below_restart,
  input  wire logic                           switch_over_current,
  input  wire logic                           switch_cycle_start,
  input  wire logic                           switch_pwm_request,
  // Boost converter controls
  output logic                                boost_switch_on,
  output logic      [1:0]                     over_voltage_limit_sel,
  output logic                                switching_halted
);

  // Stored enables for open and short detection
  logic [1:0]                     fault_en_reg;
  // Selected over-voltage level
  fault_pkg::ovp_level_t          ovp_sel_reg;
  // Over-voltage hold state
  fault_pkg::boost_state_t        boost_state_reg;
  fault_pkg::boost_state_t        boost_state_next;
  // Current-limit latch for the present cycle
  logic                           limit_hit_reg;
  // Registered flag banks
  logic [fault_pkg::FLAG_WIDTH-1:0] open_flags;
  logic [fault_pkg::FLAG_WIDTH-1:0] short_flags;
  // Qualified comparator conditions
  logic [fault_pkg::FLAG_WIDTH-1:0] open_cond;
  logic [fault_pkg::FLAG_WIDTH-1:0] short_cond;
  logic [fault_pkg::HV_COUNT-1:0]   hv_open_cond;
  logic [fault_pkg::HV_COUNT-1:0]   hv_short_cond;
  logic [fault_pkg::LV_COUNT-1:0]   lv_open_cond;
  logic [fault_pkg::LV_COUNT-1:0]   lv_short_cond;
  // Boost output reached the over-voltage level
  logic                           ovp_reached;
  // Read data next value
  logic [7:0]                     read_next;
  // Switch gate next value
  logic                           switch_next;
  // Current-limit latch next value
  logic                           limit_next;

  // Write strobes per register
  logic                           wr_fault_en;
  logic                           wr_ovp_sel;

  // Decode writes; flag registers are read-only
  assign wr_fault_en = reg_wr && (reg_addr == fault_pkg::FAULT_EN_ADDR);
  assign wr_ovp_sel  = reg_wr && (reg_addr == fault_pkg::OVP_SEL_ADDR);

  // Fault detect enables, off after reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fault_en_reg <= fault_pkg::FAULT_EN_RESET;
    end
    else if (wr_fault_en)
    begin
      // Open and short enables from bits 0 and 1
      fault_en_reg[0] <= reg_wdata[fault_pkg::OPEN_EN_BIT];
      fault_en_reg[1] <= reg_wdata[fault_pkg::SHORT_EN_BIT];
    end
  end

  // Over-voltage level select, 16V at power-up
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ovp_sel_reg <= fault_pkg::OVP_SEL_RESET;
    end
    else if (wr_ovp_sel)
    begin
      // Any of the four codes is legal
      ovp_sel_reg <= fault_pkg::ovp_level_t'(
        reg_wdata[fault_pkg::OVP_SEL_LSB +: 2]);
    end
  end

  // Drive the selected level to the analog comparator
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      over_voltage_limit_sel <= fault_pkg::OVP_SEL_RESET;
    end
    else
    begin
      over_voltage_limit_sel <= ovp_sel_reg;
    end
  end

  // Boost has touched the threshold or is being held off by it
  assign ovp_reached = boost_at_ovp || (boost_state_reg == fault_pkg::BOOST_HOLD);

  // High-voltage open: low sink, boost-fed anode, boost at OVER_VOLTAGE_LIMIT
  assign hv_open_cond = hv_sink_active & hv_sink_low
                      & hv_anode_on_boost
                      & {fault_pkg::HV_COUNT{ovp_reached}};

  // Low-voltage open: any active sink below its floor
  assign lv_open_cond = lv_sink_active & lv_sink_low;

  // High-voltage short: enabled sink, string voltage collapsed
  assign hv_short_cond = hv_sink_active & hv_string_short;

  // Low-voltage short: active LED voltage below margin
  assign lv_short_cond = lv_sink_active & lv_led_short;

  // Open register layout: HV in 1:0, LV in 6:2
  always_comb
  begin
    open_cond = '0;
    open_cond[fault_pkg::HV_FIELD_LSB +: fault_pkg::HV_COUNT] = hv_open_cond;
    open_cond[fault_pkg::LV_FIELD_LSB +: fault_pkg::LV_COUNT] = lv_open_cond;
  end

  // Short register layout: string under test in 0, LV in 6:2
  always_comb
  begin
    short_cond = '0;
    // Only one string is enabled during the test, so either reports here
    short_cond[fault_pkg::HV_FIELD_LSB] = |hv_short_cond;
    short_cond[fault_pkg::LV_FIELD_LSB +: fault_pkg::LV_COUNT] = lv_short_cond;
  end

  // Open flags, gated by the open enable
  flag_qualifier #(
    .WIDTH     (fault_pkg::FLAG_WIDTH)
  ) open_bank (
    .clk       (clk),
    .reset     (reset),
    .enable    (fault_en_reg[fault_pkg::OPEN_EN_BIT]),
    .condition (open_cond),
    .flags_reg (open_flags)
  );

  // Short flags, gated by the short enable
  flag_qualifier #(
    .WIDTH     (fault_pkg::FLAG_WIDTH)
  ) short_bank (
    .clk       (clk),
    .reset     (reset),
    .enable    (fault_en_reg[fault_pkg::SHORT_EN_BIT]),
    .condition (short_cond),
    .flags_reg (short_flags)
  );

  // Over-voltage hold: stop at threshold, restart 1V lower
  always_comb
  begin
    boost_state_next = boost_state_reg;
    unique case (boost_state_reg)
      fault_pkg::BOOST_RUN:
      begin
        // Threshold reached: halt switching
        if (boost_at_ovp)
        begin
          boost_state_next = fault_pkg::BOOST_HOLD;
        end
      end
      fault_pkg::BOOST_HOLD:
      begin
        // Output discharged below restart point
        if (boost_below_restart && !boost_at_ovp)
        begin
          boost_state_next = fault_pkg::BOOST_RUN;
        end
      end
    endcase
  end

  // Over-voltage state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      boost_state_reg <= fault_pkg::BOOST_RUN;
    end
    else
    begin
      boost_state_reg <= boost_state_next;
    end
  end

  // Current limit ends the cycle; a new cycle rearms the switch
  always_comb
  begin
    limit_next = limit_hit_reg;
    if (switch_cycle_start)
    begin
      // Next switching cycle resumes
      limit_next = 1'b0;
    end
    if (switch_over_current)
    begin
      // Limit in the same cycle wins over rearm
      limit_next = 1'b1;
    end
  end

  // Current-limit latch
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      limit_hit_reg <= 1'b0;
    end
    else
    begin
      limit_hit_reg <= limit_next;
    end
  end

  // Switch gate: request unless held by OVER_VOLTAGE_LIMIT or the current limit
  always_comb
  begin
    switch_next = switch_pwm_request;
    if (boost_state_next == fault_pkg::BOOST_HOLD)
    begin
      // Output at threshold, let it discharge
      switch_next = 1'b0;
    end
    if (limit_next)
    begin
      // Rest of this cycle stays off
      switch_next = 1'b0;
    end
  end

  // Registered switch gate drive
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      boost_switch_on <= 1'b0;
    end
    else
    begin
      boost_switch_on <= switch_next;
    end
  end

  // Registered over-voltage halt indicator
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      switching_halted <= 1'b0;
    end
    else
    begin
      switching_halted <= (boost_state_next == fault_pkg::BOOST_HOLD);
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    read_next = 8'h00;
    unique case (reg_addr)
      fault_pkg::OPEN_FLAGS_ADDR:
      begin
        // Bit 7 reserved, reads zero
        read_next = {1'b0, open_flags};
      end
      fault_pkg::SHORT_FLAGS_ADDR:
      begin
        // Bits 7 and 1 reserved, read zero
        read_next = {1'b0, short_flags};
      end
      fault_pkg::FAULT_EN_ADDR:
      begin
        // Enables in the low two bits
        read_next = {6'h00, fault_en_reg};
      end
      fault_pkg::BOOST_STATUS_ADDR:
      begin
        // Live protection state
        read_next[fault_pkg::STATUS_OVP_BIT] = (boost_state_reg == fault_pkg::BOOST_HOLD);
        read_next[fault_pkg::STATUS_OCP_BIT] = limit_hit_reg;
      end
      fault_pkg::OVP_SEL_ADDR:
      begin
        // Level select in the low two bits
        read_next = {6'h00, ovp_sel_reg};
      end
      default:
      begin
        // Unmapped offset
        read_next = 8'h00;
      end
    endcase
  end

  // Read data register, loaded on a read strobe and held otherwise
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= read_next;
    end
  end

endmodule // led_fault_flag_protection

`default_nettype wire

// >>> tb/led_fault_chk.sv
// Assertion checker for the fault flag and boost protection block
`timescale 1ns/1ns
`default_nettype none
module led_fault_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       boost_at_ovp,
  input wire logic       boost_below_restart,
  input wire logic       switch_over_current,
  input wire logic       switch_cycle_start,
  input wire logic       switch_pwm_request,
  input wire logic       boost_switch_on,
  input wire logic [1:0] over_voltage_limit_sel,
  input wire logic       switching_halted
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Write to the level select register
  wire logic       sel_wr = reg_wr && reg_addr == fault_pkg::OVP_SEL_ADDR;
  wire logic [1:0] wsel   = reg_wdata[1:0];  // Level field of write data
  chk_ovp_stop: assert property (boost_at_ovp |=> switching_halted && !boost_switch_on)
    else $error("switch not stopped at over-voltage");
  chk_ovp_hold: assert property (switching_halted && !boost_below_restart |=> switching_halted)
    else $error("hold released above restart level");
  chk_ovp_resume: assert property
    (switching_halted && boost_below_restart && !boost_at_ovp |=> !switching_halted)
    else $error("hold kept below restart level");
  chk_limit_off: assert property (switch_over_current |=> !boost_switch_on)
    else $error("switch on during current limit");
  chk_limit_resume: assert property (switch_cycle_start && !switch_over_current &&
    switch_pwm_request && !boost_at_ovp && !switching_halted |=> boost_switch_on)
    else $error("switch not resumed at new cycle");
  // Select register, then output stage: the pin moves two edges after the write
  chk_level_write: assert property
    (sel_wr |=> ##1 over_voltage_limit_sel == $past(wsel, 2))
    else $error("level select not written");
  chk_level_keep: assert property (!sel_wr |=> ##1 $stable(over_voltage_limit_sel))
    else $error("level select changed without write");
  chk_boot_state: assert property ($fell(reset) |-> over_voltage_limit_sel == 2'h0 &&
    reg_rdata == 8'h00 && !boost_switch_on)
    else $error("outputs not at power-up values");
  chk_rdata_keep: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  cover property (boost_at_ovp ##1 switching_halted);
  cover property (switch_over_current ##1 !boost_switch_on);
  cover property (sel_wr);
endmodule // led_fault_chk
bind led_fault_flag_protection led_fault_chk chk_i (
  .clk                    (clk),
  .reset                  (reset),
  .reg_addr               (reg_addr),
  .reg_wr                 (reg_wr),
  .reg_wdata              (reg_wdata),
  .reg_rd                 (reg_rd),
  .reg_rdata              (reg_rdata),
  .boost_at_ovp           (boost_at_ovp),
  .boost_below_restart    (boost_below_restart),
  .switch_over_current    (switch_over_current),
  .switch_cycle_start     (switch_cycle_start),
  .switch_pwm_request     (switch_pwm_request),
  .boost_switch_on        (boost_switch_on),
  .over_voltage_limit_sel (over_voltage_limit_sel),
  .switching_halted       (switching_halted)
);
`default_nettype wire

// >>> tb/led_string_model.sv
// Behavioural LED strings, boost output and switching cycle beside the block
`timescale 1ns/1ns
`default_nettype none
module led_string_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       switch_on,
  input  wire logic [1:0] level_sel,
  input  wire logic       cp_double,
  input  wire logic [1:0] hv_on,
  input  wire logic [1:0] hv_open,
  input  wire logic [1:0] hv_fed,
  input  wire logic [1:0] hv_shorted,
  input  wire logic [4:0] lv_on,
  input  wire logic [4:0] lv_open,
  input  wire logic [4:0] lv_shorted,
  output logic      [1:0] hv_low,
  output logic      [1:0] hv_short,
  output logic      [4:0] lv_low,
  output logic      [4:0] lv_short,
  output logic            at_ovp,
  output logic            below_restart,
  output logic            cycle_start
);
  int         vout_mv;   // Boost output in millivolts
  int         level_mv;  // Selected over-voltage level
  logic [2:0] phase;     // Switching cycle counter
  logic       load;      // A boost-fed string draws current
  assign load = |(hv_on & ~hv_open & hv_fed);
  assign level_mv = 16000 + 8000 * int'(level_sel);
  // Open string starves its sink; short collapses the string
  assign hv_low = hv_on & hv_open;
  assign hv_short = hv_on & hv_shorted;
  // Unity gain starves every low-voltage sink, so opens need doubling gain
  assign lv_low = lv_on & (lv_open | {5{!cp_double}});
  // Doubling gain lifts the LED voltage and hides shorts
  assign lv_short = lv_on & lv_shorted & {5{!cp_double}};
  assign at_ovp = vout_mv >= level_mv;
  assign below_restart = vout_mv <= level_mv - 1000;
  assign cycle_start = phase == 3'h0;
  // Switching charges the output, a load drains it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      vout_mv <= 0;
      phase <= 3'h0;
    end
    else
    begin
      vout_mv <= vout_mv + (switch_on ? 1500 : 0) - ((load && vout_mv >= 1500) ? 1500 : 0);
      phase <= phase + 3'h1;
    end
  end
endmodule // led_string_model
`default_nettype wire

// >>> tb/led_fault_flag_protection_tb_top.sv
// Self-checking bench for the fault flag and boost protection block
`timescale 1ns/1ns
`default_nettype none
module led_fault_flag_protection_tb_top;
  logic       clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] hv_on = 2'h0, hv_open = 2'h0, hv_fed = 2'h0, hv_shorted = 2'h0;
  logic [4:0] lv_on = 5'h00, lv_open = 5'h00, lv_shorted = 5'h00;
  logic       over_cur = 1'b0, pwm_req = 1'b0, cp_double = 1'b0;
  logic [1:0] hv_low, hv_short, sel;
  logic [4:0] lv_low, lv_short;
  logic       at_ovp, below_restart, cycle_start, switch_on, halted;
  int         fail_count = 0, checks_done = 0, cycles = 0;
  always #2 clk = ~clk;
  led_fault_flag_protection dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hv_sink_active(hv_on), .hv_sink_low(hv_low), .hv_anode_on_boost(hv_fed),
    .hv_string_short(hv_short), .lv_sink_active(lv_on), .lv_sink_low(lv_low),
    .lv_led_short(lv_short), .boost_at_ovp(at_ovp), .boost_below_restart(below_restart),
    .switch_over_current(over_cur), .switch_cycle_start(cycle_start),
    .switch_pwm_request(pwm_req), .boost_switch_on(switch_on),
    .over_voltage_limit_sel(sel), .switching_halted(halted));
  led_string_model strings (.clk(clk), .reset(reset), .switch_on(switch_on),
    .level_sel(sel), .cp_double(cp_double), .hv_on(hv_on), .hv_open(hv_open), .hv_fed(hv_fed),
    .hv_shorted(hv_shorted), .lv_on(lv_on), .lv_open(lv_open), .lv_shorted(lv_shorted),
    .hv_low(hv_low), .hv_short(hv_short), .lv_low(lv_low), .lv_short(lv_short),
    .at_ovp(at_ovp), .below_restart(below_restart), .cycle_start(cycle_start));
  // Byte comparison with mismatch report
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe, data checked after the sampling edge
  task automatic rd_cmp(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp(what, exp, reg_rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      complete_run();
    end
  end
  // Test sequence
  initial
  begin
    cyc(20);
    reset <= 1'b0;
    hv_on <= 2'h3;
    hv_open <= 2'h3;
    hv_fed <= 2'h3;
    hv_shorted <= 2'h3;
    lv_on <= 5'h1F;
    lv_open <= 5'h1F;
    lv_shorted <= 5'h1F;
    pwm_req <= 1'b1;
    cyc(30);
    rd_cmp("enables", fault_pkg::FAULT_EN_ADDR, 8'h00);
    rd_cmp("level", fault_pkg::OVP_SEL_ADDR, 8'h00);
    rd_cmp("open off", fault_pkg::OPEN_FLAGS_ADDR, 8'h00);
    rd_cmp("short off", fault_pkg::SHORT_FLAGS_ADDR, 8'h00);
    rd_cmp("unmapped", 8'h00, 8'h00);
    cmp("halted", 8'h01, {7'h0, halted});
    cmp("switch", 8'h00, {7'h0, switch_on});
    rd_cmp("status hold", fault_pkg::BOOST_STATUS_ADDR, 8'h01);
    $display("test defaults done");
    @(posedge clk);
    cp_double <= 1'b1;
    hv_on <= 2'h1;
    hv_fed <= 2'h2;
    lv_on <= 5'h0F;
    lv_open <= 5'h15;
    wr(fault_pkg::FAULT_EN_ADDR, 8'h01);
    rd_cmp("open unfed", fault_pkg::OPEN_FLAGS_ADDR, 8'h14);
    @(posedge clk);
    hv_on <= 2'h3;
    hv_fed <= 2'h3;
    rd_cmp("open all", fault_pkg::OPEN_FLAGS_ADDR, 8'h17);
    wr(fault_pkg::OVP_SEL_ADDR, 8'h03);
    cyc(2);
    rd_cmp("open no ovp", fault_pkg::OPEN_FLAGS_ADDR, 8'h14);
    @(posedge clk);
    hv_open <= 2'h2;
    over_cur <= 1'b1;
    cyc(2);
    #1;
    cmp("limit off", 8'h00, {7'h0, switch_on});
    rd_cmp("status limit", fault_pkg::BOOST_STATUS_ADDR, 8'h02);
    @(posedge clk);
    over_cur <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      #1;
      if (switch_on === 1'b1)
        break;
    end
    cmp("limit resume", 8'h01, {7'h0, switch_on});
    wr(fault_pkg::FAULT_EN_ADDR, 8'h00);
    rd_cmp("open cleared", fault_pkg::OPEN_FLAGS_ADDR, 8'h00);
    $display("test open done");
    wr(fault_pkg::FAULT_EN_ADDR, 8'h02);
    @(posedge clk);
    cp_double <= 1'b0;
    hv_on <= 2'h1;
    hv_shorted <= 2'h1;
    lv_on <= 5'h1F;
    lv_shorted <= 5'h0A;
    rd_cmp("short", fault_pkg::SHORT_FLAGS_ADDR, 8'h29);
    rd_cmp("open gated", fault_pkg::OPEN_FLAGS_ADDR, 8'h00);
    @(posedge clk);
    // Second string alone under test reports in the same bit
    hv_on <= 2'h2;
    hv_shorted <= 2'h2;
    lv_shorted <= 5'h00;
    rd_cmp("short two", fault_pkg::SHORT_FLAGS_ADDR, 8'h01);
    $display("test short done");
    for (int k = 0; k < 4; k++)
    begin
      wr(fault_pkg::OVP_SEL_ADDR, 8'hFC | 8'(k));
      rd_cmp("level read", fault_pkg::OVP_SEL_ADDR, 8'(k));
      cmp("level out", 8'(k), {6'h0, sel});
    end
    $display("test levels done");
    complete_run();
  end
endmodule // led_fault_flag_protection_tb_top
`default_nettype wire
